// ### ccrpsc_params.svh
// Constants of the series current regulator protection and step control.
// Assumes a 250 MHz controller clock and feedback scaled to millivolts.
`ifndef CCRPSC_PARAMS_SVH
`define CCRPSC_PARAMS_SVH
// Clock and time figures.
`define PSC_CLK_MHZ 250
`define PSC_QUAL_MS 500
`define PSC_PWR_MS 2000
// Phase timer tick divider and gate pulse length in ticks.
`define PSC_TICK_LAST 8'hff
`define PSC_GATE_TICKS 8'h64
// Firing delay limits and start value, in ticks.
`define PSC_DLY_MIN 14'h000a
`define PSC_DLY_MAX 14'h1f40
`define PSC_DLY_INIT 14'h0fa0
// Step feedback targets in millivolts.
`define PSC_STEP1_MV 12'h1a4
`define PSC_STEP2_MV 12'h1fe
`define PSC_STEP3_MV 12'h267
`define PSC_STEP4_MV 12'h30c
`define PSC_STEP5_MV 12'h3de
// Overcurrent at 105 percent of step five and open circuit at 1.5 A.
`define PSC_OC_MV 12'h410
`define PSC_OPEN_MV 12'h04a
// Register offsets and reset values.
`define PSC_A_CTRL 8'h00
`define PSC_A_STAT 8'h04
`define PSC_A_DLY 8'h08
`define PSC_A_FB 8'h0c
`define PSC_CTRL_RST 16'h4001
`define PSC_CTRL_EN 0
`define PSC_SYNC_RST 15'h7fff
`endif

// ### ccrpsc_pkg.sv
// Types shared by the regulator control modules.
// Assumes nothing of its surroundings.
package ccrpsc_pkg;
  // Brightness step, zero meaning none.
  typedef logic [2:0] ccrpsc_step_t;
  // Selector mode.
  typedef enum {CCRPSC_OFF, CCRPSC_LOCAL, CCRPSC_REMOTE} ccrpsc_mode_t;
endpackage

// ### ccrpsc_gate_if.sv
// Link between the regulation loop and the phase gate timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ccrpsc_gate_if;
  logic tick;
  logic sync_edge;
  logic enable;
  logic [13:0] delay;
  logic gate;
  modport ctl (output tick, sync_edge, enable, delay, input gate);
  modport tmr (input tick, sync_edge, enable, delay, output gate);
endinterface // ccrpsc_gate_if
`default_nettype wire

// ### ccrpsc_gate_timer.sv
// Phase-locked thyristor gate timer.
// Assumes a phase edge pulse and a slow tick from the controller.
`timescale 1ns/1ps
`default_nettype none
`include "ccrpsc_params.svh"
module ccrpsc_gate_timer (
  input wire logic clock_in, // Controller clock.
  input wire logic rst_in, // Asynchronous reset, high.
  ccrpsc_gate_if.tmr g // Loop side.
);
  import ccrpsc_pkg::*;
  logic [13:0] cnt_r, cnt_nxt;
  logic [7:0] wid_r, wid_nxt;
  logic gate_r, gate_nxt, arm_r, arm_nxt;

  // Counts ticks from each phase edge and fires at the set delay.
  always_comb begin
    cnt_nxt = cnt_r;
    wid_nxt = wid_r;
    gate_nxt = gate_r;
    arm_nxt = arm_r;
    if (!g.enable) begin
      cnt_nxt = 14'h0000;
      gate_nxt = 1'b0;
      arm_nxt = 1'b0;
    end else if (g.sync_edge) begin
      cnt_nxt = 14'h0000;
      gate_nxt = 1'b0;
      arm_nxt = 1'b1;
    end else if (g.tick) begin
      if (arm_r) begin
        cnt_nxt = cnt_r + 14'h0001;
      end
      if (arm_r && cnt_r == g.delay) begin
        gate_nxt = 1'b1;
        wid_nxt = `PSC_GATE_TICKS;
        arm_nxt = 1'b0;
      end else if (gate_r) begin
        wid_nxt = wid_r - 8'h01;
        gate_nxt = (wid_r != 8'h01);
      end
    end
  end

  // Registers the timer state.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 14'h0000;
      wid_r <= 8'h00;
      gate_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      wid_r <= wid_nxt;
      gate_r <= gate_nxt;
      arm_r <= arm_nxt;
    end
  end

  assign g.gate = gate_r;

  AST_GATE_PHASE: assert property (
    @(posedge clock_in) disable iff (rst_in)
    $rose(gate_r) |-> $past(arm_r && g.tick && cnt_r == g.delay))
    else $error("Gate fired away from its phase delay.");
endmodule // ccrpsc_gate_timer
`default_nettype wire

// ### ccrpsc_top.sv
// Protection and step control of a series current regulator.
// Assumes an APB master on clock_in, pins from the selector and remote
// block, and a feedback level in millivolts from an ADC on the same clock.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ccrpsc_params.svh"
module ccrpsc_top #(
  parameter int unsigned QUAL_CYC = `PSC_QUAL_MS * 1000 * `PSC_CLK_MHZ,
  parameter int unsigned PWR_CYC = `PSC_PWR_MS * 1000 * `PSC_CLK_MHZ
) (
  input wire logic clock_in, // Controller clock, 250 MHz.
  input wire logic rst_in, // Asynchronous reset, high.
  input wire logic psel_in, // APB select.
  input wire logic penable_in, // APB enable.
  input wire logic pwrite_in, // APB write.
  input wire logic [7:0] paddr_in, // APB byte address.
  input wire logic [31:0] pwdata_in, // APB write data.
  output logic [31:0] prdata_out, // APB read data.
  output logic pready_out, // APB ready.
  output logic pslverr_out, // APB error.
  input wire logic [4:0] step_n_in, // Local step lines, low active.
  input wire logic remote_n_in, // Selector at remote, low active.
  input wire logic [4:0] remote_step_in, // Remote step inputs.
  input wire logic jmp_three_in, // Three-step jumper.
  input wire logic jmp_ferro_in, // Ferroresonant jumper.
  input wire logic phase_ref_in, // Line phase reference.
  input wire logic power_ok_in, // Input power present.
  input wire logic [11:0] fb_mv_in, // Feedback level in mV.
  output logic contactor_out, // Input contactor drive.
  output logic remote_supply_relay_out, // Remote supply relay.
  output logic gate_out // Thyristor gate drive.
);
  import ccrpsc_pkg::*;

  // ************************************************************
  // Pin synchronisers and decode
  // ************************************************************
  logic [14:0] s1_r, s2_r;
  logic [4:0] step_n_s, rstep_s;
  logic remote_s, three_s, ferro_s, phase_s, pwr_s;

  // Highest asserted step line, zero when none.
  function automatic ccrpsc_step_t step_dec(input logic [4:0] v);
    step_dec = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (v[i]) begin
        step_dec = 3'(i + 1);
      end
    end
  endfunction

  // Two flip-flops on every selector, jumper, phase and power pin before any logic reads it.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= `PSC_SYNC_RST;
      s2_r <= `PSC_SYNC_RST;
    end else begin
      s1_r <= {power_ok_in, phase_ref_in, jmp_ferro_in, jmp_three_in,
               remote_step_in, remote_n_in, step_n_in};
      s2_r <= s1_r;
    end
  end

  assign step_n_s = s2_r[4:0];
  assign remote_s = ~s2_r[5];
  assign rstep_s = s2_r[10:6];
  assign three_s = s2_r[11];
  assign ferro_s = s2_r[12];
  assign phase_s = s2_r[13];
  assign pwr_s = s2_r[14];

  // ************************************************************
  // Step selection, protection and contactor
  // ************************************************************
  ccrpsc_mode_t mode_r, mode_nxt;
  ccrpsc_step_t step_r, step_nxt, step_raw;
  logic [31:0] oc_cnt_r, oc_cnt_nxt, op_cnt_r, op_cnt_nxt;
  logic [31:0] pw_cnt_r, pw_cnt_nxt;
  logic oc_trip_r, oc_trip_nxt, op_trip_r, op_trip_nxt;
  logic con_r, con_nxt, rly_r, rly_nxt;
  logic off_sel, pwr_clr, oc_cond, op_cond, oc_set, op_set;

  // Mode, step, trip latches and contactor drive.
  always_comb begin
    mode_nxt = CCRPSC_OFF;
    step_raw = remote_s ? step_dec(rstep_s) : step_dec(~step_n_s);
    if (remote_s) begin
      mode_nxt = CCRPSC_REMOTE;
    end else if (!step_n_s[0]) begin
      mode_nxt = CCRPSC_LOCAL;
    end
    if (three_s && step_raw > 3'h3) begin
      step_raw = 3'h3;
    end
    step_nxt = (mode_nxt == CCRPSC_OFF) ? 3'h0 : step_raw;
    off_sel = (step_nxt == 3'h0);
    pwr_clr = (pw_cnt_r >= PWR_CYC - 1);
    pw_cnt_nxt = pwr_s ? 32'h0 : (pwr_clr ? pw_cnt_r : pw_cnt_r + 32'h1);
    oc_cond = con_r && (fb_mv_in > `PSC_OC_MV);
    oc_set = oc_cond && (oc_cnt_r == QUAL_CYC - 1);
    oc_cnt_nxt = (oc_cond && !oc_set) ? oc_cnt_r + 32'h1 : 32'h0;
    op_cond = con_r && (fb_mv_in < `PSC_OPEN_MV);
    op_set = op_cond && (op_cnt_r == QUAL_CYC - 1);
    op_cnt_nxt = (op_cond && !op_set) ? op_cnt_r + 32'h1 : 32'h0;
    oc_trip_nxt = oc_set || (oc_trip_r && !off_sel && !pwr_clr);
    op_trip_nxt = op_set || (op_trip_r && !off_sel && !pwr_clr);
    con_nxt = !off_sel && pwr_s && !oc_trip_nxt && !op_trip_nxt;
    rly_nxt = (mode_nxt == CCRPSC_REMOTE) && pwr_s;
  end

  // Registers selection and protection state.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= CCRPSC_OFF;
      step_r <= 3'h0;
      oc_cnt_r <= 32'h0;
      op_cnt_r <= 32'h0;
      pw_cnt_r <= 32'h0;
      oc_trip_r <= 1'b0;
      op_trip_r <= 1'b0;
      con_r <= 1'b0;
      rly_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      step_r <= step_nxt;
      oc_cnt_r <= oc_cnt_nxt;
      op_cnt_r <= op_cnt_nxt;
      pw_cnt_r <= pw_cnt_nxt;
      oc_trip_r <= oc_trip_nxt;
      op_trip_r <= op_trip_nxt;
      con_r <= con_nxt;
      rly_r <= rly_nxt;
    end
  end

  assign contactor_out = con_r;
  assign remote_supply_relay_out = rly_r;

  // ************************************************************
  // Regulation loop
  // ************************************************************
  ccrpsc_gate_if g ();
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [13:0] dly_r, dly_nxt, dstep;
  logic [11:0] tgt, db;
  logic [7:0] div_r, div_nxt;
  logic tick_r, tick_nxt, ph_d_r, ph_d_nxt, edge_r, edge_nxt, gen_r, gen_nxt;

  // Tick divider, phase edges and integral delay update.
  always_comb begin
    div_nxt = div_r + 8'h01;
    tick_nxt = (div_r == `PSC_TICK_LAST);
    ph_d_nxt = phase_s;
    edge_nxt = phase_s ^ ph_d_r;
    gen_nxt = con_r && ctrl_r[`PSC_CTRL_EN];
    case (step_r)
      3'h1: tgt = `PSC_STEP1_MV;
      3'h2: tgt = `PSC_STEP2_MV;
      3'h3: tgt = `PSC_STEP3_MV;
      3'h4: tgt = `PSC_STEP4_MV;
      3'h5: tgt = `PSC_STEP5_MV;
      default: tgt = 12'h000;
    endcase
    db = {4'h0, tgt[11:4]} >> 4;
    dstep = ferro_s ? {6'h00, ctrl_r[15:8]} : 14'h0001;
    dly_nxt = dly_r;
    if (!gen_r) begin
      dly_nxt = `PSC_DLY_INIT;
    end else if (edge_r) begin
      if (fb_mv_in > tgt + db) begin
        dly_nxt = (dly_r > `PSC_DLY_MIN + dstep) ? dly_r - dstep
                                                 : `PSC_DLY_MIN;
      end else if (fb_mv_in + db < tgt) begin
        dly_nxt = (dly_r + dstep < `PSC_DLY_MAX) ? dly_r + dstep
                                                 : `PSC_DLY_MAX;
      end
    end
  end

  // Registers loop state.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= 8'h00;
      tick_r <= 1'b0;
      ph_d_r <= 1'b1;
      edge_r <= 1'b0;
      gen_r <= 1'b0;
      dly_r <= `PSC_DLY_INIT;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      ph_d_r <= ph_d_nxt;
      edge_r <= edge_nxt;
      gen_r <= gen_nxt;
      dly_r <= dly_nxt;
    end
  end

  // Feeds the phase gate timer.
  assign g.tick = tick_r;
  assign g.sync_edge = edge_r;
  assign g.enable = gen_r && con_r;
  assign g.delay = dly_r;
  assign gate_out = g.gate;

  ccrpsc_gate_timer u_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .g(g.tmr)
  );

  // ************************************************************
  // APB register slave
  // ************************************************************
  logic [31:0] rd_r, rd_nxt;
  logic rdy_r, rdy_nxt, err_r, err_nxt, hit;

  // Zero-wait slave: answer prepared in setup, shown in access.
  always_comb begin
    rd_nxt = 32'h0;
    hit = 1'b1;
    case (paddr_in)
      `PSC_A_CTRL: rd_nxt = {16'h0000, ctrl_r};
      `PSC_A_STAT: rd_nxt = {20'h00000, pwr_s, ferro_s, three_s, rly_r,
                             con_r, op_trip_r, oc_trip_r,
                             mode_r == CCRPSC_REMOTE, mode_r != CCRPSC_OFF,
                             step_r};
      `PSC_A_DLY: rd_nxt = {18'h00000, dly_r};
      `PSC_A_FB: rd_nxt = {20'h00000, fb_mv_in};
      default: hit = 1'b0;
    endcase
    rdy_nxt = psel_in && !penable_in;
    err_nxt = rdy_nxt && !hit;
    if (!rdy_nxt) begin
      rd_nxt = 32'h0;
    end
    ctrl_nxt = ctrl_r;
    if (psel_in && penable_in && rdy_r && pwrite_in &&
        paddr_in == `PSC_A_CTRL) begin
      ctrl_nxt = pwdata_in[15:0];
    end
  end

  // Registers the slave answer and control word.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rd_r <= 32'h0;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      ctrl_r <= `PSC_CTRL_RST;
    end else begin
      rd_r <= rd_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign prdata_out = rd_r;
  assign pready_out = rdy_r;
  assign pslverr_out = err_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  AST_OFF_IDLE: assert property (
    (step_n_s == 5'h1f && !remote_s) [*2]
    |=> !con_r && !rly_r && !gate_out)
    else $error("Outputs active with selector off.");
  AST_RELAY_REMOTE: assert property (
    (remote_s && pwr_s) |=> rly_r)
    else $error("Relay open in remote mode.");
  AST_OC_SHUT: assert property (
    oc_trip_r |-> !con_r)
    else $error("Contactor on during overcurrent trip.");
  AST_OC_QUAL: assert property (
    $rose(oc_trip_r) |-> $past(oc_cnt_r) == QUAL_CYC - 1)
    else $error("Overcurrent trip before qualification time.");
  AST_OPEN_QUAL: assert property (
    $rose(op_trip_r) |-> $past(op_cnt_r) == QUAL_CYC - 1 && !con_r)
    else $error("Open-circuit trip timing wrong.");
  AST_OC_HOLD: assert property (
    (oc_trip_r && !off_sel && !pwr_clr) |=> oc_trip_r)
    else $error("Overcurrent trip released early.");
  AST_OPEN_HOLD: assert property (
    (op_trip_r && !off_sel && !pwr_clr) |=> op_trip_r)
    else $error("Open-circuit trip released early.");
  AST_CON_ON: assert property (
    (!off_sel && pwr_s && !oc_trip_nxt && !op_trip_nxt) |=> con_r)
    else $error("Contactor off while running.");
  AST_LOOP_DIR: assert property (
    (gen_r && edge_r && fb_mv_in > tgt + db && dly_r > `PSC_DLY_MIN)
    |=> dly_r < $past(dly_r))
    else $error("Delay did not fall with high current.");
endmodule // ccrpsc_top
`default_nettype wire

// ### ccrpsc_field.sv
// Partner model: step selector switch, remote panel and line phase source.
// Assumes the bench sets its commands just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ccrpsc_field #(
  parameter int HALF = 250 // Clocks per phase half-cycle.
) (
  input wire logic clock_in, // Controller clock.
  input wire logic [1:0] pos_in, // Position: 0 off, 1 local, 2 remote.
  input wire logic [2:0] step_in, // Chosen step, zero for none.
  input wire logic hold_in, // Freezes the line phase.
  output logic [4:0] step_n_out, // Local step lines, low active.
  output logic remote_n_out, // Remote position, low active.
  output logic [4:0] remote_step_out, // Remote step inputs.
  output logic phase_ref_out // Line phase square wave.
);
  // ********************************************************************
  // Selector and remote panel
  // ********************************************************************
  int cnt = 0;
  logic ph_r = 1'b0;
  assign phase_ref_out = ph_r;
  // The switch pulls the chosen line and line zero low; the remote panel drives one line.
  always_comb begin
    step_n_out = 5'h1f;
    remote_step_out = 5'h00;
    remote_n_out = (pos_in != 2'd2);
    if (pos_in == 2'd1 && step_in != 3'd0) begin
      step_n_out[step_in - 3'd1] = 1'b0;
      step_n_out[0] = 1'b0;
    end
    if (pos_in == 2'd2 && step_in != 3'd0) begin
      remote_step_out[step_in - 3'd1] = 1'b1;
    end
  end
  // The line phase toggles every half-cycle, so both edges are exercised.
  // While held it stands still, so the gate timer can reach its delay.
  always @(posedge clock_in) begin
    if (hold_in) begin
      cnt <= cnt;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ph_r <= ~ph_r;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ccrpsc_field
`default_nettype wire

// ### ccr_protection_step_control_bench.sv
// Self-checking bench of the regulator protection and step control.
// Assumes the design files and the field model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ccr_protection_step_control_bench;
  // ********************************************************************
  // Signals and helpers
  // ********************************************************************
  localparam int QC = 20;
  localparam int PC = 30;
  localparam int HALF = 250;
  localparam int TICK = 256;
  localparam int DMIN = 10;
  logic clock_in = 1'b0;
  logic rst_in, psel, penable, pwrite, pready, pslverr, remote_n, er, hold;
  logic jmp_three, jmp_ferro, phase_ref, power_ok, contactor, relay, gate;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] step_n, remote_step;
  logic [11:0] fb;
  logic [1:0] pos;
  logic [2:0] stp, s;
  logic [11:0] tgt [5] = '{12'h1a4, 12'h1fe, 12'h267, 12'h30c, 12'h3de};
  int miscompares = 0;
  int cmp_count = 0;
  int seed, n, d0;
  ccrpsc_top #(.QUAL_CYC(QC), .PWR_CYC(PC)) u_dut (
    .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .step_n_in(step_n), .remote_n_in(remote_n),
    .remote_step_in(remote_step), .jmp_three_in(jmp_three),
    .jmp_ferro_in(jmp_ferro), .phase_ref_in(phase_ref),
    .power_ok_in(power_ok), .fb_mv_in(fb), .contactor_out(contactor),
    .remote_supply_relay_out(relay), .gate_out(gate));
  ccrpsc_field #(.HALF(HALF)) u_field (
    .clock_in(clock_in), .pos_in(pos), .step_in(stp), .hold_in(hold),
    .step_n_out(step_n), .remote_n_out(remote_n),
    .remote_step_out(remote_step), .phase_ref_out(phase_ref));
  // Free-running 250 MHz clock.
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    // Data and error are taken at the rising edge that sees pready high.
    do begin
      @(posedge clock_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rdst();
    apb(1'b0, 8'h04, 32'h0);
  endtask
  // Moves the selector and waits past the pin synchronisers.
  task automatic setsel(input logic [1:0] p, input logic [2:0] k);
    @(posedge clock_in);
    pos <= p;
    stp <= k;
    cyc(5);
    @(negedge clock_in);
  endtask
  // Counts cycles until the contactor drops, bounded.
  task automatic wait_off(output int k);
    k = 0;
    do begin
      @(negedge clock_in);
      k++;
    end while (contactor !== 1'b0 && k < QC + 10);
    if (contactor !== 1'b0) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // Firing delay change over eight phase edges at a given feedback.
  task automatic trend(input logic [11:0] f, output int dl);
    @(posedge clock_in);
    fb <= f;
    cyc(2 * HALF);
    apb(1'b0, 8'h08, 32'h0);
    d0 = int'(rd);
    cyc(8 * HALF);
    apb(1'b0, 8'h08, 32'h0);
    dl = int'(rd) - d0;
  endtask
  function automatic logic [2:0] xstep(input logic [2:0] k,
                                       input logic three);
    return (three === 1'b1 && k > 3'd3) ? 3'd3 : k;
  endfunction
  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    seed = 32'h03a1a417;
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pos = 2'd0;
    stp = 3'd0;
    jmp_three = 1'b0;
    jmp_ferro = 1'b0;
    power_ok = 1'b1;
    hold = 1'b0;
    fb = 12'h1f4;
    cyc(10);
    rst_in <= 1'b0;
    @(negedge clock_in);
    chk1("contactor", 1'b0, contactor);
    chk1("gate", 1'b0, gate);
    apb(1'b0, 8'h00, 32'h0);
    chk32("ctrl", 32'h00004001, rd);
    apb(1'b1, 8'h04, 32'hffffffff);
    rdst();
    chk32("stat_step", 32'h0, {29'h0, rd[2:0]});
    apb(1'b0, 8'h10, 32'h0);
    chk1("slverr", 1'b1, er);
    apb(1'b0, 8'h0c, 32'h0);
    chk32("fb", 32'h1f4, rd);
    $display("TEST reset done");
    for (int i = 0; i < 10; i++) begin
      s = 3'(($unsigned($random(seed)) % 5) + 1);
      @(posedge clock_in);
      jmp_three <= 1'($random(seed));
      fb <= 12'(100 + $unsigned($random(seed)) % 900);
      setsel(2'd1, s);
      rdst();
      chk32("stat_step", {29'h0, xstep(s, jmp_three)},
            {29'h0, rd[2:0]});
      chk1("sys_on", 1'b1, rd[3]);
      chk1("contactor", 1'b1, contactor);
      chk1("relay", 1'b0, relay);
    end
    @(posedge clock_in);
    jmp_three <= 1'b0;
    for (int k = 1; k <= 5; k++) begin
      setsel(2'd2, 3'(k));
      rdst();
      chk32("stat_step", 32'(k), {29'h0, rd[2:0]});
      chk1("relay", 1'b1, relay);
      chk1("contactor", 1'b1, contactor);
    end
    setsel(2'd2, 3'd0);
    chk1("contactor", 1'b0, contactor);
    setsel(2'd0, 3'd0);
    chk1("relay", 1'b0, relay);
    $display("TEST steps done");
    setsel(2'd1, 3'd5);
    @(posedge clock_in);
    fb <= 12'h44c;
    cyc(QC - 4);
    fb <= 12'h3de;
    cyc(8);
    @(negedge clock_in);
    chk1("transient", 1'b1, contactor);
    @(posedge clock_in);
    fb <= 12'h44c;
    wait_off(n);
    chk1("oc_time", 1'b1, n >= QC - 1 && n <= QC + 3);
    @(posedge clock_in);
    fb <= 12'h1f4;
    cyc(10);
    @(negedge clock_in);
    chk1("oc_hold", 1'b0, contactor);
    rdst();
    chk1("oc_flag", 1'b1, rd[5]);
    setsel(2'd0, 3'd0);
    chk1("gate", 1'b0, gate);
    rdst();
    chk1("oc_clear", 1'b0, rd[5]);
    setsel(2'd1, 3'd2);
    chk1("restart", 1'b1, contactor);
    @(posedge clock_in);
    fb <= 12'h01e;
    wait_off(n);
    chk1("open_time", 1'b1, n >= QC - 1 && n <= QC + 3);
    rdst();
    chk1("open_flag", 1'b1, rd[6]);
    @(posedge clock_in);
    fb <= 12'h1fe;
    power_ok <= 1'b0;
    cyc(PC - 10);
    power_ok <= 1'b1;
    cyc(8);
    @(negedge clock_in);
    chk1("short_loss", 1'b0, contactor);
    @(posedge clock_in);
    power_ok <= 1'b0;
    cyc(PC + 5);
    power_ok <= 1'b1;
    cyc(8);
    @(negedge clock_in);
    chk1("long_loss", 1'b1, contactor);
    $display("TEST protection done");
    for (int k = 0; k < 5; k++) begin
      setsel(2'd1, 3'(k + 1));
      trend(tgt[k] + 12'h028, n);
      chk1("dly_down", 1'b1, n < 0);
      trend(tgt[k] - 12'h028, n);
      chk1("dly_up", 1'b1, n > 0);
    end
    apb(1'b1, 8'h00, 32'h00000801);
    @(posedge clock_in);
    jmp_ferro <= 1'b1;
    setsel(2'd1, 3'd1);
    rdst();
    chk1("ferro_flag", 1'b1, rd[10]);
    trend(12'h1cc, n);
    chk1("ferro_gain", 1'b1, n <= -8);
    $display("TEST loop done");
    // Full gain drives the delay to its floor, then the phase is held.
    apb(1'b1, 8'h00, 32'h0000ff01);
    cyc(20 * HALF);
    @(posedge clock_in);
    hold <= 1'b1;
    n = 0;
    while (gate !== 1'b1 && n < 16 * TICK) begin
      @(posedge clock_in);
      n++;
    end
    chk1("gate_fire", 1'b1, gate);
    chk1("gate_time", 1'b1,
         n >= (DMIN - 1) * TICK && n <= (DMIN + 2) * TICK);
    @(posedge clock_in);
    hold <= 1'b0;
    $display("TEST gate done");
    print_verdict();
  end
endmodule // ccr_protection_step_control_bench
`default_nettype wire
